// ---- src/osd_pkg.sv ----
// Function
// - interrupt with recover bit clears ratio enable
// - ratio field selects CPU ratio one to 2^N
// - ratio applies only while ratio enable set
// - postscaler divides fast RC by 1..64, 256
// - trim field is signed two's-complement offset
// - switching enabled only for configuration 00
// - disabled: new source ignored, current follows config
// - disabled: switch request reads and stays zero
// - high byte writable only after 78h, 9Ah
// - low byte writable only after 46h, 57h
// - equal sources: clear request, abort switch
// - valid switch clears lock and clock fail
// - start target, wait startup timer, PLL lock
// - count 10 new-clock cycles before changeover
// - changeover clears request, copies new source
// - old source off, except kept low-power/secondary
// - primary submode fixed by configuration
// - secondary starts on module request or enable
// - mode 11/01 oscillator, 00 digital pins
// - mode 01 low drive, default high drive
// - shared three-bit source encoding
package osd_pkg;

   // ----------------------------------------------------------------
   // register map (word indices on the plain port)
   // ----------------------------------------------------------------
   localparam logic [3:0] ADDR_CLK_DIV = 4'h0;
   localparam logic [3:0] ADDR_TRIM    = 4'h1;
   localparam logic [3:0] ADDR_OSC_HI  = 4'h2;
   localparam logic [3:0] ADDR_OSC_LO  = 4'h3;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int CD_ROI_BIT   = 15;
   localparam int CD_RATIO_LSB = 12;
   localparam int CD_EN_BIT    = 11;
   localparam int CD_POST_LSB  = 8;
   localparam int LO_LOCK_BIT  = 5;
   localparam int LO_FAIL_BIT  = 3;
   localparam int LO_PSLP_BIT  = 2;
   localparam int LO_SECONDARY_OSC_BIT  = 1;
   localparam int LO_REQ_BIT   = 0;
   localparam int HI_CUR_LSB   = 4;

   // ----------------------------------------------------------------
   // reset values, keys, timing
   // ----------------------------------------------------------------
   localparam logic [2:0] POST_RESET   = 3'h1;
   localparam logic [7:0] KEY_HI_1     = 8'h78;
   localparam logic [7:0] KEY_HI_2     = 8'h9a;
   localparam logic [7:0] KEY_LO_1     = 8'h46;
   localparam logic [7:0] KEY_LO_2     = 8'h57;
   localparam int         SYNC_CYCLES  = 10;
   localparam logic [1:0] SWM_ENABLED  = 2'h0;

   // ----------------------------------------------------------------
   // source encoding
   // ----------------------------------------------------------------
   localparam logic [2:0] SRC_FRC      = 3'h0;
   localparam logic [2:0] SRC_FRC_PLL  = 3'h1;
   localparam logic [2:0] SRC_PRI      = 3'h2;
   localparam logic [2:0] SRC_PRI_PLL  = 3'h3;
   localparam logic [2:0] SRC_SEC      = 3'h4;
   localparam logic [2:0] SRC_LOW_POWER_RC_OSC     = 3'h5;
   localparam logic [2:0] SRC_FRC_POST = 3'h7;

   // primary submode codes; 00 is external clock (no crystal)
   localparam logic [1:0] PSUB_EC      = 2'h0;
   localparam logic [1:0] PSUB_OFF     = 2'h3;
   localparam logic [1:0] SMODE_DIGITAL = 2'h0;
   localparam logic [1:0] SMODE_LOW_PWR = 2'h1;

   typedef struct packed {
      logic pll;
      logic pri;
      logic sec;
      logic low_power_rc_osc;
      logic fast_rc_osc;
   } osd_osc_en_t;

   typedef struct packed {
      logic [1:0] switch_monitor_cfg;
      logic [2:0] initial_source_cfg;
      logic [1:0] primary_osc_submode;
      logic [1:0] secondary_osc_mode;
      logic       watchdog_enable;
   } osd_cfg_t;

endpackage

// ---- src/osd_osc_switch_doze_divider.sv ----
// The plain strobed port and the address map were decided locally.
`timescale 1ns/100ps
`default_nettype none
module osd_osc_switch_doze_divider
#(
   parameter int SYNC_CYCLES = osd_pkg::SYNC_CYCLES
)
(
   // clock and reset
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   // register port
   input  wire logic [3:0]           addr_i,
   input  wire logic [15:0]          wr_data_i,
   input  wire logic                 wr_i,
   input  wire logic                 rd_i,
   output logic      [15:0]          rd_data_o,
   // configuration and system events
   input  wire osd_pkg::osd_cfg_t    cfg_i,
   input  wire logic                 irq_i,
   input  wire logic                 clock_fail_i,
   input  wire logic                 sec_request_i,
   // oscillator status
   input  wire logic                 startup_done_i,
   input  wire logic                 pll_lock_i,
   input  wire logic                 new_clk_tick_i,
   input  wire logic                 frc_tick_i,
   // clock control outputs
   output osd_pkg::osd_osc_en_t      osc_en_o,
   output logic      [2:0]           sys_clk_sel_o,
   output logic                      switch_busy_o,
   output logic                      cpu_tick_o,
   output logic                      frc_post_tick_o,
   output logic signed [5:0]         fast_rc_trim_o,
   output logic                      fail_safe_monitor_o,
   output logic                      sec_pins_digital_o,
   output logic                      sec_low_drive_o
);

   // elaboration-time guard: the sync counter is four bits wide
   if (SYNC_CYCLES < 1 || SYNC_CYCLES > 15)
   begin
      $error("SYNC_CYCLES must lie in 1..15");
   end

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // oscillators each source needs
   function automatic osd_pkg::osd_osc_en_t src_need(input logic [2:0] s);
      osd_pkg::osd_osc_en_t m;
      m = '0;
      unique case (s)
         osd_pkg::SRC_FRC, osd_pkg::SRC_FRC_POST : m.fast_rc_osc = 1'b1;
         osd_pkg::SRC_FRC_PLL :
         begin
            m.fast_rc_osc = 1'b1;
            m.pll = 1'b1;
         end
         osd_pkg::SRC_PRI     : m.pri = 1'b1;
         osd_pkg::SRC_PRI_PLL :
         begin
            m.pri = 1'b1;
            m.pll = 1'b1;
         end
         osd_pkg::SRC_SEC     : m.sec = 1'b1;
         osd_pkg::SRC_LOW_POWER_RC_OSC    : m.low_power_rc_osc = 1'b1;
         default              : m.fast_rc_osc = 1'b1;
      endcase
      return m;
   endfunction

   function automatic logic uses_pll(input logic [2:0] s);
      return (s == osd_pkg::SRC_FRC_PLL) || (s == osd_pkg::SRC_PRI_PLL);
   endfunction

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef enum logic [6:0] {
      ST_IDLE  = 7'b0000001,
      ST_CHECK = 7'b0000010,
      ST_START = 7'b0000100,
      ST_OST   = 7'b0001000,
      ST_PLL   = 7'b0010000,
      ST_SYNC  = 7'b0100000,
      ST_SWAP  = 7'b1000000
   } osd_state_t;

   osd_state_t state;
   osd_state_t next_state;

   logic       recover_on_irq;
   logic [2:0] ratio_sel;
   logic       ratio_enable;
   logic [2:0] fast_rc_postscale;
   logic [5:0] fast_rc_trim;
   logic [2:0] current_source_sel;
   logic [2:0] new_source_sel;
   logic       switch_request;
   logic       pll_lock;
   logic       clock_fail_flag;
   logic       pri_sleep_keep;
   logic       secondary_osc_enable;
   logic       loaded;
   logic [1:0] hi_stage;
   logic [1:0] lo_stage;
   logic [3:0] sync_cnt;
   logic [6:0] doze_cnt;
   logic [7:0] post_cnt;

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   wire        any_access  = wr_i | rd_i;
   wire        wr_div      = wr_i && addr_i == osd_pkg::ADDR_CLK_DIV;
   wire        wr_trim     = wr_i && addr_i == osd_pkg::ADDR_TRIM;
   wire        wr_hi       = wr_i && addr_i == osd_pkg::ADDR_OSC_HI;
   wire        wr_lo       = wr_i && addr_i == osd_pkg::ADDR_OSC_LO;
   wire [7:0]  wr_byte     = wr_data_i[7:0];
   // only configuration 00 enables switching and the monitor
   wire        sw_enabled  = cfg_i.switch_monitor_cfg == osd_pkg::SWM_ENABLED;
   // protected write lands only right after both keys
   wire        hi_accept   = wr_hi && hi_stage == 2'd2;
   // same guard on the low byte
   wire        lo_accept   = wr_lo && lo_stage == 2'd2;
   // any access other than the next key restarts the count
   wire [1:0]  next_hi_stage =
      !any_access                                          ? hi_stage :
      (wr_hi && hi_stage == 2'd1 && wr_byte == osd_pkg::KEY_HI_2) ? 2'd2 :
      (wr_hi && wr_byte == osd_pkg::KEY_HI_1)              ? 2'd1 : 2'd0;
   wire [1:0]  next_lo_stage =
      !any_access                                          ? lo_stage :
      (wr_lo && lo_stage == 2'd1 && wr_byte == osd_pkg::KEY_LO_2) ? 2'd2 :
      (wr_lo && wr_byte == osd_pkg::KEY_LO_1)              ? 2'd1 : 2'd0;

   wire        same_source = current_source_sel == new_source_sel;
   wire        target_pll  = uses_pll(new_source_sel);
   // the submode is a strap; only it decides crystal or clock input
   wire        pri_crystal = cfg_i.primary_osc_submode != osd_pkg::PSUB_EC &&
                             cfg_i.primary_osc_submode != osd_pkg::PSUB_OFF;
   wire        target_xtal =
      ((new_source_sel == osd_pkg::SRC_PRI || new_source_sel == osd_pkg::SRC_PRI_PLL)
        && pri_crystal) || new_source_sel == osd_pkg::SRC_SEC;
   wire        sync_done   = new_clk_tick_i &&
                             sync_cnt == 4'(SYNC_CYCLES - 1);
   wire        switching   = !(state inside {ST_IDLE, ST_CHECK});

   // secondary oscillator usable only in the oscillator codes
   wire        sec_osc_mode = cfg_i.secondary_osc_mode != osd_pkg::SMODE_DIGITAL;
   // module request or enable bit starts the secondary
   wire        sec_keep     = sec_osc_mode &&
                              (secondary_osc_enable || sec_request_i);
   // low-power RC stays up for the watchdog or the monitor
   wire        low_power_rc_osc_keep    = cfg_i.watchdog_enable || sw_enabled;
   osd_pkg::osd_osc_en_t need_cur;
   osd_pkg::osd_osc_en_t need_new;
   osd_pkg::osd_osc_en_t next_osc_en;
   assign need_cur = src_need(current_source_sel);
   assign need_new = src_need(new_source_sel);
   // target powered while the switch runs, old one dropped after
   always_comb
   begin
      next_osc_en      = need_cur | (switching ? need_new : '0);
      next_osc_en.low_power_rc_osc = next_osc_en.low_power_rc_osc | low_power_rc_osc_keep;
      next_osc_en.sec  = (next_osc_en.sec & sec_osc_mode) | sec_keep;
   end

   // ratio forced to 1:1 while disabled
   wire [2:0]  eff_ratio  = ratio_enable ? ratio_sel : 3'h0;
   // cpu runs once per 2^N peripheral cycles
   wire [6:0]  doze_mask  = 7'((8'h01 << eff_ratio) - 8'h01);
   wire        doze_wrap  = (doze_cnt & doze_mask) == doze_mask;
   // codes 0..6 are 2^code, code 7 is 256
   wire [7:0]  post_mask  = (fast_rc_postscale == 3'h7) ? 8'hff :
                            8'((9'h001 << fast_rc_postscale) - 9'h001);
   wire        post_wrap  = frc_tick_i && (post_cnt & post_mask) == post_mask;

   wire [15:0] div_word   = {recover_on_irq, ratio_sel, ratio_enable,
                             fast_rc_postscale, 8'h00};
   wire [15:0] hi_word    = {8'h00, 1'b0, current_source_sel, 1'b0, new_source_sel};
   wire [15:0] lo_word    = {8'h00, 2'b00, pll_lock, 1'b0, clock_fail_flag,
                             pri_sleep_keep, secondary_osc_enable, switch_request};
   wire [15:0] next_rd    =
      !rd_i                           ? 16'h0000 :
      addr_i == osd_pkg::ADDR_CLK_DIV ? div_word :
      addr_i == osd_pkg::ADDR_TRIM    ? {10'h000, fast_rc_trim} :
      addr_i == osd_pkg::ADDR_OSC_HI  ? hi_word :
      addr_i == osd_pkg::ADDR_OSC_LO  ? lo_word : 16'h0000;

   // ----------------------------------------------------------------
   // switch sequencer
   // ----------------------------------------------------------------
   always_comb
   begin
      next_state = state;
      unique case (state)
         ST_IDLE  : if (switch_request && sw_enabled) next_state = ST_CHECK;
         ST_CHECK : next_state = same_source ? ST_IDLE : ST_START;
         ST_START : next_state = target_xtal ? ST_OST :
                                 target_pll  ? ST_PLL : ST_SYNC;
         // crystal waits for the startup timer
         ST_OST   : if (startup_done_i) next_state = target_pll ? ST_PLL : ST_SYNC;
         ST_PLL   : if (pll_lock_i) next_state = ST_SYNC;
         ST_SYNC  : if (sync_done) next_state = ST_SWAP;
         ST_SWAP  : next_state = ST_IDLE;
         default  : next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         state    <= ST_IDLE;
         sync_cnt <= 4'h0;
      end
      else
      begin
         state    <= sw_enabled ? next_state : ST_IDLE;
         sync_cnt <= (state != ST_SYNC) ? 4'h0 :
                     new_clk_tick_i     ? sync_cnt + 4'h1 : sync_cnt;
      end
   end

   // ----------------------------------------------------------------
   // source selection and osc control flags
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         loaded               <= 1'b0;
         current_source_sel   <= osd_pkg::SRC_FRC_POST;
         new_source_sel       <= osd_pkg::SRC_FRC_POST;
         hi_stage             <= 2'd0;
         lo_stage             <= 2'd0;
      end
      else
      begin
         loaded   <= 1'b1;
         hi_stage <= next_hi_stage;
         lo_stage <= next_lo_stage;
         // selection strap wins while switching is off
         if (!loaded || !sw_enabled)
            current_source_sel <= cfg_i.initial_source_cfg;
         else if (state == ST_SWAP)
            current_source_sel <= new_source_sel;
         if (!loaded)
            new_source_sel <= cfg_i.initial_source_cfg;
         // changing the target mid-switch would corrupt the sequence
         else if (hi_accept && !switching)
            new_source_sel <= wr_byte[2:0];
      end
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         switch_request       <= 1'b0;
         pri_sleep_keep       <= 1'b0;
         secondary_osc_enable <= 1'b0;
      end
      else
      begin
         if (lo_accept)
         begin
            pri_sleep_keep       <= wr_byte[osd_pkg::LO_PSLP_BIT];
            secondary_osc_enable <= wr_byte[osd_pkg::LO_SECONDARY_OSC_BIT];
         end
         // request held low while switching is off
         if (!sw_enabled)
            switch_request <= 1'b0;
         // abort and success both clear the request
         else if ((state == ST_CHECK && same_source) || state == ST_SWAP)
            switch_request <= 1'b0;
         else if (lo_accept && wr_byte[osd_pkg::LO_REQ_BIT])
            switch_request <= 1'b1;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         pll_lock        <= 1'b0;
         clock_fail_flag <= 1'b0;
      end
      else
      begin
         // valid switch start clears lock status
         if (state == ST_CHECK && !same_source)
            pll_lock <= 1'b0;
         else if (state inside {ST_START, ST_OST, ST_PLL})
            pll_lock <= target_pll && pll_lock_i && state == ST_PLL;
         else if (state inside {ST_SYNC, ST_SWAP})
            pll_lock <= pll_lock | (target_pll & pll_lock_i);
         else
            pll_lock <= uses_pll(current_source_sel) && pll_lock_i;
         // monitor event wins over any clear in the same cycle
         if (clock_fail_i && sw_enabled)
            clock_fail_flag <= 1'b1;
         // valid switch start clears the fail flag
         else if (state == ST_CHECK && !same_source)
            clock_fail_flag <= 1'b0;
         else if (lo_accept && !wr_byte[osd_pkg::LO_FAIL_BIT])
            clock_fail_flag <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // divider and trim registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         recover_on_irq    <= 1'b0;
         ratio_sel         <= 3'h0;
         ratio_enable      <= 1'b0;
         fast_rc_postscale <= osd_pkg::POST_RESET;
         fast_rc_trim      <= 6'h00;
      end
      else
      begin
         if (wr_div)
         begin
            recover_on_irq    <= wr_data_i[osd_pkg::CD_ROI_BIT];
            ratio_sel         <= wr_data_i[osd_pkg::CD_RATIO_LSB +: 3];
            fast_rc_postscale <= wr_data_i[osd_pkg::CD_POST_LSB +: 3];
         end
         // software setting the enable wins over a same-cycle interrupt
         if (wr_div)
            ratio_enable <= wr_data_i[osd_pkg::CD_EN_BIT];
         // interrupt drops back to full cpu speed
         else if (irq_i && recover_on_irq)
            ratio_enable <= 1'b0;
         if (wr_trim)
            fast_rc_trim <= wr_data_i[5:0];
      end
   end

   // ----------------------------------------------------------------
   // clock enables and outputs
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         doze_cnt        <= 7'h00;
         post_cnt        <= 8'h00;
         cpu_tick_o      <= 1'b0;
         frc_post_tick_o <= 1'b0;
      end
      else
      begin
         // restart on a ratio change so the first cpu slot is full length
         doze_cnt        <= (wr_div || doze_wrap) ? 7'h00 : doze_cnt + 7'h01;
         cpu_tick_o      <= doze_wrap;
         if (wr_div)
            post_cnt <= 8'h00;
         else if (frc_tick_i)
            post_cnt <= post_wrap ? 8'h00 : post_cnt + 8'h01;
         frc_post_tick_o <= post_wrap;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         rd_data_o           <= 16'h0000;
         osc_en_o            <= '0;
         sys_clk_sel_o       <= osd_pkg::SRC_FRC_POST;
         switch_busy_o       <= 1'b0;
         fast_rc_trim_o      <= 6'sh00;
         fail_safe_monitor_o <= 1'b0;
         sec_pins_digital_o  <= 1'b0;
         sec_low_drive_o     <= 1'b0;
      end
      else
      begin
         rd_data_o           <= next_rd;
         osc_en_o            <= next_osc_en;
         sys_clk_sel_o       <= current_source_sel;
         switch_busy_o       <= switching;
         // trim handed to the analog side as a signed offset
         fast_rc_trim_o      <= $signed(fast_rc_trim);
         fail_safe_monitor_o <= sw_enabled;
         // digital pins only in the non-oscillator code
         sec_pins_digital_o  <= !sec_osc_mode;
         sec_low_drive_o     <= cfg_i.secondary_osc_mode == osd_pkg::SMODE_LOW_PWR;
      end
   end

endmodule
`default_nettype wire

// ---- dv/osd_chk.sv ----
`timescale 1ns/100ps
`default_nettype none
module osd_chk
#(
   parameter int SYNC_CYCLES = 10
)
(
   // clock, reset, register port
   input wire logic              clk_i,
   input wire logic              rst_i,
   input wire logic [3:0]        addr_i,
   input wire logic              wr_i,
   input wire logic              rd_i,
   input wire logic [15:0]       rd_data_o,
   // configuration and clock control
   input wire osd_pkg::osd_cfg_t cfg_i,
   input wire logic [2:0]        sys_clk_sel_o,
   input wire logic              switch_busy_o,
   input wire logic signed [5:0] fast_rc_trim_o,
   input wire logic              fail_safe_monitor_o,
   input wire logic              sec_pins_digital_o,
   input wire logic              sec_low_drive_o
);
   // ----
   // checks
   // ----
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wire sw_en = cfg_i.switch_monitor_cfg == osd_pkg::SWM_ENABLED;
   // busy must stay high for at least 8 cycles once it rises
   sequence s_busy_start; $rose(switch_busy_o); endsequence
   sequence s_busy_hold; switch_busy_o [*8]; endsequence
   a_rd_idle_zero: assert property (!$past(rd_i) |-> rd_data_o == 16'h0000)
      else $error("read data outside read cycle");
   a_rd_unmapped: assert property ($past(rd_i) && $past(addr_i) > 4'h3 |-> rd_data_o == 16'h0000)
      else $error("unmapped read not zero");
   a_trim_by_write: assert property ($changed(fast_rc_trim_o) |->
      $past(wr_i, 2) && $past(addr_i, 2) == osd_pkg::ADDR_TRIM)
      else $error("trim moved without write");
   a_mon_follow: assert property (!rst_i |=> fail_safe_monitor_o == sw_en)
      else $error("monitor enable wrong");
   a_sec_digital: assert property (!rst_i |=>
      sec_pins_digital_o == (cfg_i.secondary_osc_mode == osd_pkg::SMODE_DIGITAL))
      else $error("secondary pin mode wrong");
   a_sec_low_drive: assert property (!rst_i |=>
      sec_low_drive_o == (cfg_i.secondary_osc_mode == osd_pkg::SMODE_LOW_PWR))
      else $error("secondary drive wrong");
   a_busy_needs_en: assert property (switch_busy_o |-> sw_en)
      else $error("switch while disabled");
   a_busy_min_len: assert property (s_busy_start |-> s_busy_hold)
      else $error("switch too short");
   a_sel_after_busy: assert property ($changed(sys_clk_sel_o) |-> $past(switch_busy_o)
      || $past(switch_busy_o, 2) || $past(switch_busy_o, 3) || $past(rst_i, 2)
      || $past(rst_i, 3) || $past(rst_i, 4)) else $error("source changed outside switch");
   a_req_held_zero: assert property ($past(rd_i) && $past(addr_i) == osd_pkg::ADDR_OSC_LO
      && !sw_en |-> rd_data_o[osd_pkg::LO_REQ_BIT] == 1'b0) else $error("request bit set");
endmodule
bind osd_osc_switch_doze_divider osd_chk #(.SYNC_CYCLES(SYNC_CYCLES)) u_chk (
   .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i),
   .rd_data_o(rd_data_o), .cfg_i(cfg_i), .sys_clk_sel_o(sys_clk_sel_o),
   .switch_busy_o(switch_busy_o), .fast_rc_trim_o(fast_rc_trim_o),
   .fail_safe_monitor_o(fail_safe_monitor_o), .sec_pins_digital_o(sec_pins_digital_o),
   .sec_low_drive_o(sec_low_drive_o));
`default_nettype wire

// ---- dv/tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb;
   // ----
   // stimulus and results
   // ----
   logic                  clk_i = 1'b0;
   logic                  rst_i = 1'b1;
   logic [3:0]            addr_i = 4'h0;
   logic [15:0]           wr_data_i = 16'h0000;
   logic                  wr_i = 1'b0;
   logic                  rd_i = 1'b0;
   osd_pkg::osd_cfg_t     cfg_i = '{2'h0, 3'h7, 2'h1, 2'h1, 1'b0};
   logic                  irq_i = 1'b0;
   logic                  fail_i = 1'b0;
   logic                  sec_req_i = 1'b0;
   logic [15:0]           rd_data_o;
   osd_pkg::osd_osc_en_t  osc_en_o;
   logic [2:0]            sel_o;
   logic                  busy_o;
   logic                  cpu_o;
   logic                  post_o;
   logic signed [5:0]     trim_o;
   logic [2:0]            modes_o;
   int                    err_count = 0;
   int                    cmp_count = 0;
   int                    cpu_n;
   int                    post_n;
   int                    div [8] = '{1, 2, 4, 8, 16, 32, 64, 256};
   localparam logic [3:0] HI = osd_pkg::ADDR_OSC_HI;
   localparam logic [3:0] LO = osd_pkg::ADDR_OSC_LO;
   localparam logic [3:0] CD = osd_pkg::ADDR_CLK_DIV;
   localparam logic [3:0] TR = osd_pkg::ADDR_TRIM;
   always #2.5 clk_i = ~clk_i;
   // oscillators report ready and tick every cycle to keep waits short
   osd_osc_switch_doze_divider uut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
      .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .cfg_i(cfg_i),
      .irq_i(irq_i), .clock_fail_i(fail_i), .sec_request_i(sec_req_i), .startup_done_i(1'b1),
      .pll_lock_i(1'b1), .new_clk_tick_i(1'b1), .frc_tick_i(1'b1), .osc_en_o(osc_en_o),
      .sys_clk_sel_o(sel_o), .switch_busy_o(busy_o), .cpu_tick_o(cpu_o),
      .frc_post_tick_o(post_o), .fast_rc_trim_o(trim_o),
      .fail_safe_monitor_o(modes_o[2]), .sec_pins_digital_o(modes_o[1]),
      .sec_low_drive_o(modes_o[0]));
   task automatic print_verdict();
      $display("compared %0d, wrong %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_n(input int got, input int exp);
      chk(16'(got), 16'(exp));
   endtask
   // one bus cycle; strobes stay up only until the next call or idle
   task automatic acc(input logic w, input logic r, input logic [3:0] a, input logic [15:0] d);
      wr_i <= w;
      rd_i <= r;
      addr_i <= a;
      wr_data_i <= d;
      @(posedge clk_i);
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      acc(1'b1, 1'b0, a, d);
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] exp);
      acc(1'b0, 1'b1, a, 16'h0000);
      rd_i <= 1'b0;
      #1;
      chk(rd_data_o, exp);
   endtask
   task automatic idle(input int n);
      wr_i <= 1'b0;
      rd_i <= 1'b0;
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic keys(input logic [3:0] a, input logic [7:0] k1, k2, d);
      wr(a, {8'h00, k1});
      wr(a, {8'h00, k2});
      wr(a, {8'h00, d});
   endtask
   task automatic count(input int n);
      cpu_n = 0;
      post_n = 0;
      repeat (n)
      begin
         idle(1);
         cpu_n += int'(cpu_o === 1'b1);
         post_n += int'(post_o === 1'b1);
      end
   endtask
   task automatic wait_busy(input logic v);
      int i;
      for (i = 0; i < 200 && busy_o !== v; i++)
         idle(1);
      if (i == 200)
      begin
         err_count++;
         $display("wrong value at %0t: switch wait ran out", $time);
         print_verdict();
      end
   endtask
   task automatic do_reset(input osd_pkg::osd_cfg_t c);
      cfg_i <= c;
      rst_i <= 1'b1;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      idle(2);
   endtask
   initial
   begin
      do_reset('{2'h0, 3'h7, 2'h1, 2'h1, 1'b0});
      rd(CD, 16'h0100);
      rd(TR, 16'h0000);
      rd(HI, 16'h0077);
      rd(4'h9, 16'h0000);
      chk({13'h0, modes_o}, 16'h0005);
      $display("reset values done");
      for (int i = 0; i < 8; i++)
      begin
         wr(CD, {1'b0, 3'(i), 1'b1, 3'(i), 8'h00});
         idle(2);
         count(512);
         chk_n(cpu_n, 512 >> i);
         chk_n(post_n, 512 / div[i]);
      end
      wr(CD, 16'h7000);
      idle(2);
      count(64);
      chk_n(cpu_n, 64);
      wr(CD, 16'hb800);
      irq_i <= 1'b1;
      idle(1);
      irq_i <= 1'b0;
      rd(CD, 16'hb000);
      wr(CD, 16'h3800);
      irq_i <= 1'b1;
      idle(1);
      irq_i <= 1'b0;
      rd(CD, 16'h3800);
      wr(TR, 16'h0020);
      rd(TR, 16'h0020);
      chk({10'h0, trim_o}, 16'h0020);
      wr(TR, 16'hffff);
      rd(TR, 16'h003f);
      sec_req_i <= 1'b1;
      idle(3);
      chk({15'h0, osc_en_o.sec}, 16'h0001);
      sec_req_i <= 1'b0;
      $display("divider and trim done");
      wr(HI, 16'h0000);
      rd(HI, 16'h0077);
      wr(HI, 16'h0078);
      rd(CD, 16'h3800);
      keys(HI, 8'h9a, 8'h00, 8'h00);
      rd(HI, 16'h0077);
      keys(HI, 8'h78, 8'h9a, 8'h00);
      rd(HI, 16'h0070);
      fail_i <= 1'b1;
      idle(1);
      fail_i <= 1'b0;
      rd(LO, 16'h0008);
      keys(LO, 8'h46, 8'h57, 8'h09);
      wait_busy(1'b1);
      wait_busy(1'b0);
      idle(3);
      rd(HI, 16'h0000);
      rd(LO, 16'h0000);
      chk({13'h0, sel_o}, 16'h0000);
      chk({11'h0, osc_en_o}, 16'h0003);
      keys(LO, 8'h46, 8'h57, 8'h01);
      idle(4);
      rd(LO, 16'h0000);
      chk({15'h0, busy_o}, 16'h0000);
      $display("clock switch done");
      do_reset('{2'h2, 3'h7, 2'h1, 2'h0, 1'b0});
      keys(HI, 8'h78, 8'h9a, 8'h00);
      keys(LO, 8'h46, 8'h57, 8'h01);
      idle(4);
      rd(LO, 16'h0000);
      chk({13'h0, sel_o}, 16'h0007);
      chk({13'h0, modes_o}, 16'h0002);
      $display("switching disabled done");
      print_verdict();
   end
endmodule
`default_nettype wire
